// ===== hw/rcc_pkg.sv
package rcc_pkg;
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    // Register offsets
    localparam logic [7:0] OFS_THR_LOW = 8'h12;
    localparam logic [7:0] OFS_SCALING = 8'h13;
    localparam logic [7:0] OFS_INV_RES = 8'h14;
    localparam logic [7:0] OFS_BACK_EMF = 8'h15;
    localparam logic [7:0] OFS_FLT_DAMP = 8'h16;
    localparam logic [7:0] OFS_ERR_CORR = 8'h17;
    localparam logic [7:0] OFS_PI_PROP = 8'h18;
    // Reset values
    localparam logic [7:0] RST_THR_LOW = 8'hff;
    localparam logic [7:0] RST_SCALING = 8'h7f;
    localparam logic [7:0] RST_INV_RES = 8'h00;
    localparam logic [7:0] RST_BACK_EMF = 8'h00;
    localparam logic [7:0] RST_FLT_DAMP = 8'h00;
    localparam logic [7:0] RST_ERR_CORR = 8'h45;
    localparam logic [7:0] RST_PI_PROP = 8'h21;
    // Writable mask of the damping register; low nibble is reserved
    localparam logic [7:0] MASK_FLT_DAMP = 8'hf0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // Decoded scale factors and window percentages
    localparam logic [13:0] RES_SCALE_0 = 14'h0002;
    localparam logic [13:0] RES_SCALE_1 = 14'h0040;
    localparam logic [13:0] RES_SCALE_2 = 14'h0400;
    localparam logic [13:0] RES_SCALE_3 = 14'h2000;
    localparam logic [17:0] EMF_SCALE_0 = 18'h0_1800;
    localparam logic [17:0] EMF_SCALE_1 = 18'h0_3000;
    localparam logic [17:0] EMF_SCALE_2 = 18'h1_8000;
    localparam logic [17:0] EMF_SCALE_3 = 18'h3_0000;
    localparam logic [6:0] THR_SCALE_0 = 7'h02;
    localparam logic [6:0] THR_SCALE_1 = 7'h08;
    localparam logic [6:0] THR_SCALE_2 = 7'h10;
    localparam logic [6:0] THR_SCALE_3 = 7'h40;
    localparam logic [5:0] WIN_PCT_0 = 6'h14;
    localparam logic [5:0] WIN_PCT_1 = 6'h1e;
    localparam logic [5:0] WIN_PCT_2 = 6'h28;
    localparam logic [5:0] WIN_PCT_3 = 6'h32;
    localparam int THR_W = 10;
    localparam int LIMIT_W = 17;
    // Bit positions inside the damping register and the threshold pair
    localparam int INVQ_LSB = 4;
    localparam int INVQ_W = 4;
    localparam int THR_LOW_W = 8;

    typedef struct packed {
        logic [1:0] resistanceScaleSel;
        logic [1:0] emfConstScaleSel;
        logic [1:0] thresholdScaleSel;
        logic [1:0] thresholdHigh;
    } rcc_scaling_s;

    typedef struct packed {
        logic correctionPulseDisable;
        logic [2:0] mechResponseFilter;
        logic [1:0] extraRippleWindow;
        logic [1:0] missedRippleWindow;
    } rcc_errcorr_s;

    typedef struct packed {
        logic [13:0] resistanceScale;
        logic [17:0] emfConstScale;
        logic [LIMIT_W-1:0] rippleLimit;
        logic [7:0] inverseResistance;
        logic [7:0] emfConstant;
        logic [3:0] bandpassInvQ;
        logic correctionPulseDisable;
        logic [2:0] mechResponseFilter;
        logic [5:0] extraRipplePct;
        logic [5:0] missedRipplePct;
        logic [7:0] piProportional;
    } rcc_cfg_s;
endpackage

// ===== hw/rcc_config_regs.sv
`timescale 1ns/10ps
module rcc_config_regs
    import rcc_pkg::*;
#(
    parameter int COUNT_W = LIMIT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Register port from the serial control interface
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [REG_DW-1:0] regWrData,
    output logic [REG_DW-1:0] regRdData,
    // Ripple counting datapath
    input wire logic [COUNT_W-1:0] rippleCount,
    input wire logic bridgeOffOnThreshold,
    output rcc_cfg_s cfgOut,
    output logic overThreshold,
    output logic bridgeHiZ
);

    function automatic logic [5:0] winPct(input logic [1:0] code);
        case (code)
            2'b00: winPct = WIN_PCT_0;
            2'b01: winPct = WIN_PCT_1;
            2'b10: winPct = WIN_PCT_2;
            default: winPct = WIN_PCT_3;
        endcase
    endfunction

    logic [7:0] thrLow_ff;
    rcc_scaling_s scaling_ff;
    logic [7:0] invRes_ff;
    logic [7:0] backEmf_ff;
    logic [7:0] fltDamp_ff;
    rcc_errcorr_s errCorr_ff;
    logic [7:0] piProp_ff;
    logic [REG_DW-1:0] regRdData_ff;
    rcc_cfg_s cfg_ff;
    logic overThr_ff;
    logic bridgeHiZ_ff;

    wire logic wrThrLow = regWrEn && (regAddr == OFS_THR_LOW);
    wire logic wrScaling = regWrEn && (regAddr == OFS_SCALING);
    wire logic wrInvRes = regWrEn && (regAddr == OFS_INV_RES);
    wire logic wrBackEmf = regWrEn && (regAddr == OFS_BACK_EMF);
    wire logic wrFltDamp = regWrEn && (regAddr == OFS_FLT_DAMP);
    wire logic wrErrCorr = regWrEn && (regAddr == OFS_ERR_CORR);
    wire logic wrPiProp = regWrEn && (regAddr == OFS_PI_PROP);

    logic [13:0] resScale;
    logic [17:0] emfScale;
    logic [6:0] thrScale;
    logic [THR_W-1:0] rippleThreshold;
    logic [LIMIT_W-1:0] rippleLimit;
    logic [REG_DW-1:0] nxt_regRdData;
    rcc_cfg_s nxt_cfg;

    always_comb begin
        case (scaling_ff.resistanceScaleSel)
            2'b00: resScale = RES_SCALE_0;
            2'b01: resScale = RES_SCALE_1;
            2'b10: resScale = RES_SCALE_2;
            default: resScale = RES_SCALE_3;
        endcase
    end

    always_comb begin
        case (scaling_ff.emfConstScaleSel)
            2'b00: emfScale = EMF_SCALE_0;
            2'b01: emfScale = EMF_SCALE_1;
            2'b10: emfScale = EMF_SCALE_2;
            default: emfScale = EMF_SCALE_3;
        endcase
    end

    always_comb begin
        case (scaling_ff.thresholdScaleSel)
            2'b00: thrScale = THR_SCALE_0;
            2'b01: thrScale = THR_SCALE_1;
            2'b10: thrScale = THR_SCALE_2;
            default: thrScale = THR_SCALE_3;
        endcase
    end

    assign rippleThreshold = {scaling_ff.thresholdHigh, thrLow_ff};
    assign rippleLimit = LIMIT_W'(rippleThreshold) * LIMIT_W'(thrScale);

    always_comb begin
        nxt_cfg.resistanceScale = resScale;
        nxt_cfg.emfConstScale = emfScale;
        nxt_cfg.rippleLimit = rippleLimit;
        nxt_cfg.inverseResistance = invRes_ff;
        nxt_cfg.emfConstant = backEmf_ff;
        nxt_cfg.bandpassInvQ = fltDamp_ff[INVQ_LSB +: INVQ_W];
        nxt_cfg.correctionPulseDisable = errCorr_ff.correctionPulseDisable;
        nxt_cfg.mechResponseFilter = errCorr_ff.mechResponseFilter;
        nxt_cfg.extraRipplePct = winPct(errCorr_ff.extraRippleWindow);
        nxt_cfg.missedRipplePct = winPct(errCorr_ff.missedRippleWindow);
        nxt_cfg.piProportional = piProp_ff;
    end

    always_comb begin
        case (regAddr)
            OFS_THR_LOW: nxt_regRdData = thrLow_ff;
            OFS_SCALING: nxt_regRdData = scaling_ff;
            OFS_INV_RES: nxt_regRdData = invRes_ff;
            OFS_BACK_EMF: nxt_regRdData = backEmf_ff;
            OFS_FLT_DAMP: nxt_regRdData = fltDamp_ff & MASK_FLT_DAMP;
            OFS_ERR_CORR: nxt_regRdData = errCorr_ff;
            OFS_PI_PROP: nxt_regRdData = piProp_ff;
            default: nxt_regRdData = READ_UNMAPPED;
        endcase
    end

    // Comparison uses the live count; both sides widened so neither is truncated
    localparam int CMP_W = (COUNT_W > LIMIT_W) ? COUNT_W : LIMIT_W;
    wire logic [CMP_W-1:0] countWide = CMP_W'(rippleCount);
    wire logic [CMP_W-1:0] limitWide = CMP_W'(rippleLimit);
    wire logic nxt_overThr = countWide > limitWide;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thrLow_ff <= RST_THR_LOW;
            scaling_ff <= RST_SCALING;
            invRes_ff <= RST_INV_RES;
            backEmf_ff <= RST_BACK_EMF;
            fltDamp_ff <= RST_FLT_DAMP;
            errCorr_ff <= RST_ERR_CORR;
            piProp_ff <= RST_PI_PROP;
        end else if (clkEn) begin
            if (wrThrLow) thrLow_ff <= regWrData;
            if (wrScaling) scaling_ff <= regWrData;
            // A zero write is stored as is; host must avoid it
            if (wrInvRes) invRes_ff <= regWrData;
            if (wrBackEmf) backEmf_ff <= regWrData;
            if (wrFltDamp) fltDamp_ff <= regWrData & MASK_FLT_DAMP;
            if (wrErrCorr) errCorr_ff <= regWrData;
            if (wrPiProp) piProp_ff <= regWrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData_ff <= READ_UNMAPPED;
            cfg_ff <= '0;
            overThr_ff <= 1'b0;
            bridgeHiZ_ff <= 1'b0;
        end else if (clkEn) begin
            if (regRdEn) regRdData_ff <= nxt_regRdData;
            cfg_ff <= nxt_cfg;
            overThr_ff <= nxt_overThr;
            bridgeHiZ_ff <= nxt_overThr && bridgeOffOnThreshold;
        end
    end

    assign regRdData = regRdData_ff;
    assign cfgOut = cfg_ff;
    assign overThreshold = overThr_ff;
    assign bridgeHiZ = bridgeHiZ_ff;

    // Views used only by the checks below
    wire rcc_scaling_s wrScalingView = regWrData;
    wire logic addrMapped = (regAddr >= OFS_THR_LOW) && (regAddr <= OFS_PI_PROP);

    chk_reset_scaling: assert property (@(posedge clk) !rst_n |=> scaling_ff == RST_SCALING)
        else $error("scaling register not at reset value");
    chk_reset_errcorr: assert property (@(posedge clk) !rst_n |=> errCorr_ff == RST_ERR_CORR)
        else $error("error correction register not at reset value");
    chk_reset_thr_low: assert property (@(posedge clk) !rst_n |=> thrLow_ff == RST_THR_LOW)
        else $error("threshold low register not at reset value");
    chk_reset_outputs: assert property (@(posedge clk)
        !rst_n |=> !overThreshold && !bridgeHiZ && regRdData == READ_UNMAPPED)
        else $error("outputs not cleared by reset");

    chk_res_scale: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.resistanceScaleSel == 2'b10 |=> cfgOut.resistanceScale == RES_SCALE_2)
        else $error("resistance scale decode wrong");
    chk_res_scale_low: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.resistanceScaleSel == 2'b00 |=> cfgOut.resistanceScale == RES_SCALE_0)
        else $error("resistance scale decode wrong");
    chk_res_scale_one: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.resistanceScaleSel == 2'b01 |=> cfgOut.resistanceScale == RES_SCALE_1)
        else $error("resistance scale decode wrong");
    chk_res_scale_top: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.resistanceScaleSel == 2'b11 |=> cfgOut.resistanceScale == RES_SCALE_3)
        else $error("resistance scale decode wrong");

    chk_emf_scale: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.emfConstScaleSel == 2'b11 |=> cfgOut.emfConstScale == EMF_SCALE_3)
        else $error("back-emf scale decode wrong");
    chk_emf_scale_low: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.emfConstScaleSel == 2'b00 |=> cfgOut.emfConstScale == EMF_SCALE_0)
        else $error("back-emf scale decode wrong");
    chk_emf_scale_one: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.emfConstScaleSel == 2'b01 |=> cfgOut.emfConstScale == EMF_SCALE_1)
        else $error("back-emf scale decode wrong");
    chk_emf_scale_two: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.emfConstScaleSel == 2'b10 |=> cfgOut.emfConstScale == EMF_SCALE_2)
        else $error("back-emf scale decode wrong");

    chk_thr_scale_two: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.thresholdScaleSel == 2'b00
        |=> cfgOut.rippleLimit == LIMIT_W'($past(rippleThreshold)) * LIMIT_W'(THR_SCALE_0))
        else $error("threshold scale decode wrong");
    chk_thr_scale_eight: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.thresholdScaleSel == 2'b01
        |=> cfgOut.rippleLimit == LIMIT_W'($past(rippleThreshold)) * LIMIT_W'(THR_SCALE_1))
        else $error("threshold scale decode wrong");
    chk_thr_scale_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.thresholdScaleSel == 2'b10
        |=> cfgOut.rippleLimit == LIMIT_W'($past(rippleThreshold)) * LIMIT_W'(THR_SCALE_2))
        else $error("threshold scale decode wrong");
    chk_thr_scale_top: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && scaling_ff.thresholdScaleSel == 2'b11
        |=> cfgOut.rippleLimit == LIMIT_W'($past(rippleThreshold)) * LIMIT_W'(THR_SCALE_3))
        else $error("threshold scale decode wrong");
    chk_thr_limit: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn |=> cfgOut.rippleLimit ==
            LIMIT_W'($past(rippleThreshold)) * LIMIT_W'($past(thrScale)))
        else $error("ripple limit mismatch");
    chk_thr_high: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && wrScaling
        |=> rippleThreshold[THR_W-1:THR_LOW_W] == $past(wrScalingView.thresholdHigh))
        else $error("threshold upper bits not loaded");
    chk_thr_low_load: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && wrThrLow |=> rippleThreshold[THR_LOW_W-1:0] == $past(regWrData))
        else $error("threshold low bits not loaded");

    chk_inv_res_out: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn |=> cfgOut.inverseResistance == $past(invRes_ff))
        else $error("inverse resistance not passed on");
    chk_emf_const_out: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn |=> cfgOut.emfConstant == $past(backEmf_ff))
        else $error("back-emf parameter not passed on");
    chk_inv_q_out: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn |=> cfgOut.bandpassInvQ == $past(fltDamp_ff[INVQ_LSB +: INVQ_W]))
        else $error("bandpass inverse-q not passed on");
    chk_damp_mask: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && wrFltDamp |=> fltDamp_ff == ($past(regWrData) & MASK_FLT_DAMP))
        else $error("damping register stored reserved bits");
    chk_pulse_dis_out: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn |=> cfgOut.correctionPulseDisable == $past(errCorr_ff.correctionPulseDisable))
        else $error("correction pulse disable not passed on");
    chk_mech_filt_out: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn |=> cfgOut.mechResponseFilter == $past(errCorr_ff.mechResponseFilter))
        else $error("mechanical response filter not passed on");

    chk_extra_win_low: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && errCorr_ff.extraRippleWindow == 2'b00 |=> cfgOut.extraRipplePct == WIN_PCT_0)
        else $error("extra ripple window decode wrong");
    chk_extra_win_top: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && errCorr_ff.extraRippleWindow == 2'b11 |=> cfgOut.extraRipplePct == WIN_PCT_3)
        else $error("extra ripple window decode wrong");
    chk_missed_win_low: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && errCorr_ff.missedRippleWindow == 2'b00 |=> cfgOut.missedRipplePct == WIN_PCT_0)
        else $error("missed ripple window decode wrong");
    chk_missed_win_top: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && errCorr_ff.missedRippleWindow == 2'b11 |=> cfgOut.missedRipplePct == WIN_PCT_3)
        else $error("missed ripple window decode wrong");

    chk_over_set: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && rippleCount > rippleLimit |=> overThreshold)
        else $error("over threshold not raised");
    chk_over_clear: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && rippleCount <= rippleLimit |=> !overThreshold)
        else $error("over threshold raised below limit");
    chk_bridge_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && !bridgeOffOnThreshold |=> !bridgeHiZ)
        else $error("bridge off while disabled");
    chk_over_thr: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && rippleCount > rippleLimit && bridgeOffOnThreshold |=> bridgeHiZ && overThreshold)
        else $error("bridge not off past threshold");
    chk_bridge_below: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && rippleCount <= rippleLimit |=> !bridgeHiZ)
        else $error("bridge off below threshold");

    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && regRdEn && regAddr == OFS_FLT_DAMP |=> (regRdData & ~MASK_FLT_DAMP) == '0)
        else $error("reserved bits read nonzero");
    chk_hold_value: assert property (@(posedge clk) disable iff (!rst_n)
        !regWrEn |=> $stable(invRes_ff) && $stable(backEmf_ff))
        else $error("register changed without write");
    chk_freeze_cfg: assert property (@(posedge clk) disable iff (!rst_n)
        !clkEn |=> $stable(cfgOut) && $stable(regRdData) && $stable(overThreshold))
        else $error("outputs moved while clock enable low");
    chk_freeze_regs: assert property (@(posedge clk) disable iff (!rst_n)
        !clkEn |=> $stable(scaling_ff) && $stable(errCorr_ff) && $stable(thrLow_ff))
        else $error("registers moved while clock enable low");
    chk_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && regRdEn && !addrMapped |=> regRdData == READ_UNMAPPED)
        else $error("unmapped read returned data");
    chk_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && wrPiProp |=> piProp_ff == $past(regWrData))
        else $error("write did not land");
endmodule

// ===== tb/rcc_host_model.sv
`timescale 1ns/10ps
module rcc_host_model
    import rcc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port toward the device
    output logic regWrEn,
    output logic regRdEn,
    output logic [REG_AW-1:0] regAddr,
    output logic [REG_DW-1:0] regWrData,
    input wire logic [REG_DW-1:0] regRdData
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // Idle bus shows inverted values so a stale address is never mistaken for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == OFS_INV_RES && d == 8'h00) return;
        @(negedge clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import rcc_pkg::*;
    logic clk, rst_n, clkEn, regWrEn, regRdEn, bridgeOff, over, hiz;
    logic [7:0] regAddr, regWrData, regRdData, rdv;
    logic [16:0] rippleCount;
    rcc_cfg_s cfg;
    int failures = 0;
    int n_checks = 0;
    int resTab [4] = '{2, 64, 1024, 8192};
    int emfSh [4] = '{8, 9, 12, 13};
    int thrTab [4] = '{2, 8, 16, 64};

    rcc_config_regs u_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .rippleCount(rippleCount), .bridgeOffOnThreshold(bridgeOff), .cfgOut(cfg),
        .overThreshold(over), .bridgeHiZ(hiz));
    rcc_host_model u_host (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, rdv);
        chk("regRdData", exp, rdv);
    endtask
    task automatic conclude();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tReset();
        logic [7:0] expv [7] = '{8'hff, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h45, 8'h21};
        for (int i = 0; i < 7; i++) begin
            rdChk(8'h12 + i[7:0], expv[i]);
        end
        rdChk(8'h11, 8'h00);
        chk("rippleLimit", 32'h0000_ffc0, cfg.rippleLimit);
        chk("resistanceScale", 64, cfg.resistanceScale);
        chk("missedRipplePct", 30, cfg.missedRipplePct);
    endtask
    task automatic tDecode();
        u_host.wr(OFS_THR_LOW, 8'h05);
        for (int c = 0; c < 4; c++) begin
            u_host.wr(OFS_SCALING, {c[1:0], c[1:0], c[1:0], c[1:0]});
            @(negedge clk);
            chk("resistanceScale", resTab[c], cfg.resistanceScale);
            chk("emfConstScale", 24 << emfSh[c], cfg.emfConstScale);
            chk("rippleLimit", {c[1:0], 8'h05} * thrTab[c], cfg.rippleLimit);
        end
    endtask
    task automatic tErrCorr();
        logic [7:0] v;
        for (int c = 0; c < 4; c++) begin
            v = {c[0], 3'(7 - c), c[1:0], 2'(3 - c)};
            u_host.wr(OFS_ERR_CORR, v);
            @(negedge clk);
            chk("correctionPulseDisable", c[0], cfg.correctionPulseDisable);
            chk("mechResponseFilter", 7 - c, cfg.mechResponseFilter);
            chk("extraRipplePct", 20 + 10 * c, cfg.extraRipplePct);
            chk("missedRipplePct", 50 - 10 * c, cfg.missedRipplePct);
            rdChk(OFS_ERR_CORR, v);
        end
    endtask
    task automatic tParams();
        u_host.wr(OFS_INV_RES, 8'h5a);
        u_host.wr(OFS_BACK_EMF, 8'ha5);
        u_host.wr(OFS_FLT_DAMP, 8'hff);
        u_host.wr(OFS_PI_PROP, 8'h3c);
        u_host.wr(8'h19, 8'h77);
        @(negedge clk);
        chk("inverseResistance", 8'h5a, cfg.inverseResistance);
        chk("emfConstant", 8'ha5, cfg.emfConstant);
        chk("bandpassInvQ", 4'hf, cfg.bandpassInvQ);
        chk("piProportional", 8'h3c, cfg.piProportional);
        rdChk(OFS_FLT_DAMP, 8'hf0);
        rdChk(8'h19, 8'h00);
        // A write while the clock enable is low must not land
        clkEn = 1'b0;
        u_host.wr(OFS_BACK_EMF, 8'h11);
        clkEn = 1'b1;
        rdChk(OFS_BACK_EMF, 8'ha5);
    endtask
    task automatic tThreshold();
        u_host.wr(OFS_THR_LOW, 8'h03);
        u_host.wr(OFS_SCALING, 8'h00);
        for (int i = 0; i < 4; i++) begin
            bridgeOff = i[1];
            rippleCount = 17'(6 + i % 2);
            repeat (2) @(negedge clk);
            chk("overThreshold", i % 2, over);
            chk("bridgeHiZ", i == 3, hiz);
        end
    endtask
    task automatic tMidReset();
        u_host.wr(OFS_PI_PROP, 8'h5c);
        u_host.wr(OFS_ERR_CORR, 8'h9a);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk("overThreshold", 0, over);
        chk("bridgeHiZ", 0, hiz);
        chk("rippleLimit", 0, cfg.rippleLimit);
        rst_n = 1'b1;
        rdChk(OFS_PI_PROP, RST_PI_PROP);
        rdChk(OFS_ERR_CORR, RST_ERR_CORR);
        rdChk(OFS_THR_LOW, RST_THR_LOW);
        @(negedge clk);
        chk("missedRipplePct", 30, cfg.missedRipplePct);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        rippleCount = '0;
        bridgeOff = 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        tReset();
        tDecode();
        tErrCorr();
        tParams();
        tThreshold();
        tMidReset();
        conclude();
    end
endmodule
